// *** hw/xba_arb.sv ***
// External bus arbitration state machine with transfer attribute pins
// How it works
// RULE_01 - Drive transfer-in-progress low during own transfers
// RULE_02 - Drive it high when idle but granted
// RULE_03 - Float it while an external master runs
// RULE_04 - Keep it low across back-to-back cycles
// RULE_05 - Pin setting picks transfer-active or port bit
// RULE_06 - Pin setting picks transfer type or port bits
// RULE_07 - Type codes: normal, DMA, emulator, CPU space
// RULE_08 - Drive type pins only as bus master
// RULE_09 - Pin setting picks modifier or port bits
// RULE_10 - Drive modifier pins only as bus master
// RULE_11 - Normal-access modifier codes; reserved ones excluded
// RULE_12 - Two-wire mode uses grant and bus-driven only
// RULE_13 - Three-wire mode adds bus request for arbiter
// RULE_14 - State changes only on rising clock edges
// RULE_15 - Either reset source forces idle reset state
// RULE_16 - Leave reset by grant: implicit or external
// RULE_17 - Implicit master floats bus, bus-driven negated
// RULE_18 - Flag external mastership for monitoring logic
// RULE_19 - Granted request starts access and bus-driven at once
// RULE_20 - Finish running cycle before releasing the bus
// RULE_21 - Request held until the transfer has started
// RULE_22 - Burst series counts as one cycle
// RULE_23 - External master state: outputs floated, bus-driven negated
// RULE_24 - Explicit master drives bus, bus-driven asserted
`timescale 1ns/10ps
module xba_arb (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wdog_reset,
    input wire logic three_wire,
    input wire xba_pkg::xba_pin_cfg_s pin_cfg,
    input wire xba_pkg::xba_attr_s port_dout,
    input wire xba_pkg::xba_attr_s port_doe_n,
    input wire xba_pkg::xba_req_s core_req,
    input wire logic bus_grant_n,
    input wire logic hard_reset_in_n,
    input wire logic xfer_ack_n,
    output logic req_taken,
    output xba_pkg::xba_attr_s attr_o,
    output xba_pkg::xba_attr_s attr_oe_n,
    output logic xfer_start_n,
    output logic bus_driven_n,
    output logic bus_request_n,
    output logic addr_ctl_oe_n,
    output logic ext_master,
    output xba_pkg::xba_arb_e arb_state
);
    import xba_pkg::*;

    typedef struct packed {
        xba_arb_e arb;
        logic busy;
        logic [1:0] beats;
        logic [1:0] xtype;
        logic [2:0] xmod;
        logic ack_prev_n;
        logic taken;
        logic start_n;
        logic drv_n;
        logic req_n;
        logic bus_oe_n;
        logic ext;
        xba_attr_s pin_o;
        xba_attr_s pin_oe_n;
    } xba_st_s;

    localparam xba_st_s ST_RST = '{ARB_RESET, 1'h0, BEAT_LAST, XTYPE_NORMAL, XMOD_PUSH,
        PIN_NEG, 1'h0, PIN_NEG, PIN_NEG, PIN_NEG, PIN_NEG, 1'h0, ATTR_IDLE, ATTR_IDLE};

    xba_st_s st_q;
    xba_st_s st_d;
    logic [2:0] sync_lvl;
    logic grant;
    logic in_reset;
    logic ack_fall;
    logic beat_end;
    logic cycle_end;
    logic may_start;
    logic start;
    logic explicit_d;
    logic drive_active;
    logic [2:0] xmod_fixed;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    xba_sync #(
        .W(3),
        .RST_VAL(SYNC_RST_VAL)
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in({bus_grant_n, hard_reset_in_n, xfer_ack_n}),
        .level_out(sync_lvl)
    );

    assign grant = (sync_lvl[2] == PIN_ASSERT);
    assign in_reset = (sync_lvl[1] == PIN_ASSERT) | wdog_reset;
    // Ack may stay low several cycles; count its falling edge once
    assign ack_fall = (sync_lvl[0] == PIN_ASSERT) & (st_q.ack_prev_n == PIN_NEG);
    assign beat_end = st_q.busy & ack_fall;
    // RULE_22 one cycle per burst
    assign cycle_end = beat_end & (st_q.beats == BEAT_LAST);

    // ------------------------------------------------------------
    // Start of an access
    // ------------------------------------------------------------
    // RULE_19 start as soon as granted
    assign may_start = (st_q.arb == ARB_IMPLICIT) | (st_q.arb == ARB_EXTERNAL)
        | ((st_q.arb == ARB_EXPLICIT) & (~st_q.busy | cycle_end));
    // Taken pulse blocks a second take of the same request
    assign start = ~in_reset & grant & core_req.valid & ~st_q.taken & may_start;

    // RULE_11 reserved normal modifiers become user data
    always_comb begin
        xmod_fixed = core_req.xmod;
        if (core_req.xtype == XTYPE_NORMAL &&
            (core_req.xmod == XMOD_RSVD_LO || core_req.xmod == XMOD_RSVD_HI)) begin
            xmod_fixed = XMOD_USER_DATA;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.start_n = PIN_NEG;
        st_d.taken = 1'h0;
        st_d.ack_prev_n = sync_lvl[0];

        // RULE_07 type code passed to the pins
        if (start) begin
            st_d.busy = 1'h1;
            st_d.beats = core_req.extra_beats;
            st_d.xtype = core_req.xtype;
            st_d.xmod = xmod_fixed;
            st_d.start_n = PIN_ASSERT;
            st_d.taken = 1'h1;
        end else if (beat_end) begin
            // RULE_22 bus held until last beat
            if (cycle_end) begin
                st_d.busy = 1'h0;
            end else begin
                st_d.beats = st_q.beats - BEAT_STEP;
            end
        end

        case (st_q.arb)
            ARB_RESET: begin
                // RULE_16 exit by grant level
                st_d.arb = grant ? ARB_IMPLICIT : ARB_EXTERNAL;
            end
            ARB_IMPLICIT: begin
                // RULE_17 wait for a request
                if (!grant) begin
                    st_d.arb = ARB_EXTERNAL;
                end else if (start) begin
                    st_d.arb = ARB_EXPLICIT;
                end
            end
            ARB_EXPLICIT: begin
                // RULE_20 release only after the cycle ends
                if (!grant && (!st_q.busy || cycle_end)) begin
                    st_d.arb = ARB_EXTERNAL;
                end
            end
            ARB_EXTERNAL: begin
                // RULE_23 wait for the next grant
                if (start) begin
                    st_d.arb = ARB_EXPLICIT;
                end else if (grant) begin
                    st_d.arb = ARB_IMPLICIT;
                end
            end
            default: begin
                st_d.arb = ARB_RESET;
            end
        endcase

        // RULE_15 either reset source wins
        if (in_reset) begin
            st_d.arb = ARB_RESET;
            st_d.busy = 1'h0;
            st_d.start_n = PIN_NEG;
            st_d.taken = 1'h0;
        end

        explicit_d = (st_d.arb == ARB_EXPLICIT);
        // RULE_02 driven while granted, idle or not
        drive_active = explicit_d | (st_d.arb == ARB_IMPLICIT);

        // RULE_24 bus-driven and bus outputs while explicit
        st_d.drv_n = explicit_d ? PIN_ASSERT : PIN_NEG;
        st_d.bus_oe_n = explicit_d ? PIN_ASSERT : PIN_NEG;
        // RULE_18 mastership flag for chip-select logic
        st_d.ext = (st_d.arb == ARB_EXTERNAL);

        // RULE_21 request held through the start edge
        // RULE_13 only the three-wire arbiter sees it
        // RULE_12 two-wire mode leaves request negated
        st_d.req_n = (three_wire & core_req.valid & ~st_q.taken & ~in_reset)
            ? PIN_ASSERT : PIN_NEG;

        // RULE_05 pin or port bit
        // RULE_01 low while busy
        // RULE_04 busy never drops between chained cycles
        // RULE_03 floated outside implicit and explicit states
        if (pin_cfg.active_bus) begin
            st_d.pin_o.active = st_d.busy ? PIN_ASSERT : PIN_NEG;
            st_d.pin_oe_n.active = drive_active ? PIN_ASSERT : PIN_NEG;
        end else begin
            st_d.pin_o.active = port_dout.active;
            st_d.pin_oe_n.active = port_doe_n.active;
        end

        // RULE_06 type pins or port bits
        // RULE_08 type pins driven only as master
        if (pin_cfg.type_bus) begin
            st_d.pin_o.xtype = st_d.xtype;
            st_d.pin_oe_n.xtype = {2{~explicit_d}};
        end else begin
            st_d.pin_o.xtype = port_dout.xtype;
            st_d.pin_oe_n.xtype = port_doe_n.xtype;
        end

        // RULE_09 modifier pins or port bits
        // RULE_10 modifier pins driven only as master
        if (pin_cfg.mod_bus) begin
            st_d.pin_o.xmod = st_d.xmod;
            st_d.pin_oe_n.xmod = {3{~explicit_d}};
        end else begin
            st_d.pin_o.xmod = port_dout.xmod;
            st_d.pin_oe_n.xmod = port_doe_n.xmod;
        end
    end

    // RULE_14 single rising-edge register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign req_taken = st_q.taken;
    assign attr_o = st_q.pin_o;
    assign attr_oe_n = st_q.pin_oe_n;
    assign xfer_start_n = st_q.start_n;
    assign bus_driven_n = st_q.drv_n;
    assign bus_request_n = st_q.req_n;
    assign addr_ctl_oe_n = st_q.bus_oe_n;
    assign ext_master = st_q.ext;
    assign arb_state = st_q.arb;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_granted_req;
        (st_q.arb == ARB_IMPLICIT) && grant && core_req.valid && !st_q.taken && !in_reset;
    endsequence
    sequence s_chain;
        cycle_end && start;
    endsequence
    sequence s_held_cycle;
        st_q.busy && !grant && !cycle_end && !in_reset;
    endsequence

    chk_active_busy: assert property ( // RULE_01
        st_q.busy && $past(pin_cfg.active_bus) |-> !attr_o.active && !attr_oe_n.active)
        else $error("transfer-active not low during own transfer");

    chk_active_idle: assert property ( // RULE_02
        st_q.arb == ARB_IMPLICIT && $past(pin_cfg.active_bus)
        |-> attr_o.active && !attr_oe_n.active)
        else $error("transfer-active not driven high while idle and granted");

    chk_active_float: assert property ( // RULE_03
        st_q.arb == ARB_EXTERNAL && $past(pin_cfg.active_bus) |-> attr_oe_n.active)
        else $error("transfer-active driven under external master");

    chk_active_chain: assert property ( // RULE_04
        s_chain ##0 pin_cfg.active_bus |=> !attr_o.active [*2])
        else $error("transfer-active released between chained cycles");

    chk_active_port: assert property ( // RULE_05
        !$past(pin_cfg.active_bus) |-> attr_o.active == $past(port_dout.active))
        else $error("port bit seven not passed through");

    chk_type_port: assert property ( // RULE_06
        !$past(pin_cfg.type_bus) |-> attr_oe_n.xtype == $past(port_doe_n.xtype))
        else $error("type pins not handed to the port");

    chk_type_code: assert property ( // RULE_07
        start ##1 pin_cfg.type_bus |=> attr_o.xtype == $past(core_req.xtype, 2))
        else $error("type code differs from the request");

    chk_type_float: assert property ( // RULE_08
        st_q.arb != ARB_EXPLICIT && $past(pin_cfg.type_bus) |-> &attr_oe_n.xtype)
        else $error("type pins driven while not bus master");

    chk_mod_port: assert property ( // RULE_09
        !$past(pin_cfg.mod_bus) |-> attr_o.xmod == $past(port_dout.xmod))
        else $error("modifier pins not handed to the port");

    chk_mod_float: assert property ( // RULE_10
        st_q.arb != ARB_EXPLICIT && $past(pin_cfg.mod_bus) |-> &attr_oe_n.xmod)
        else $error("modifier pins driven while not bus master");

    chk_mod_code: assert property ( // RULE_11
        st_q.busy && st_q.xtype == XTYPE_NORMAL
        |-> st_q.xmod != XMOD_RSVD_LO && st_q.xmod != XMOD_RSVD_HI)
        else $error("reserved modifier issued on a normal access");

    chk_two_wire: assert property ( // RULE_12
        !$past(three_wire) |-> bus_request_n)
        else $error("bus request asserted in two-wire mode");

    chk_reset_enter: assert property ( // RULE_15
        in_reset |=> st_q.arb == ARB_RESET && bus_driven_n && addr_ctl_oe_n && !st_q.busy)
        else $error("reset did not idle the arbiter");

    chk_reset_exit: assert property ( // RULE_16
        st_q.arb == ARB_RESET && !in_reset
        |=> st_q.arb == ($past(grant) ? ARB_IMPLICIT : ARB_EXTERNAL))
        else $error("wrong state after reset");

    chk_impl_quiet: assert property ( // RULE_17
        st_q.arb == ARB_IMPLICIT |-> bus_driven_n && addr_ctl_oe_n && xfer_start_n)
        else $error("implicit master drives the bus");

    chk_ext_flag: assert property ( // RULE_18
        st_q.arb == ARB_EXTERNAL |-> ext_master)
        else $error("external mastership not flagged");

    chk_start_now: assert property ( // RULE_19
        s_granted_req |=> !xfer_start_n && !bus_driven_n && st_q.arb == ARB_EXPLICIT)
        else $error("granted request did not start at once");

    chk_cycle_held: assert property ( // RULE_20
        s_held_cycle |=> st_q.arb == ARB_EXPLICIT && !bus_driven_n)
        else $error("bus released during a running cycle");

    chk_req_hold: assert property ( // RULE_21
        start && three_wire |=> !bus_request_n ##1 bus_request_n)
        else $error("bus request not held over the start edge");

    chk_burst_one: assert property ( // RULE_22
        beat_end && !cycle_end && !in_reset |=> st_q.busy)
        else $error("burst series split");

    chk_ext_quiet: assert property ( // RULE_23
        st_q.arb == ARB_EXTERNAL |-> bus_driven_n && addr_ctl_oe_n)
        else $error("external master state drives the bus");

    chk_explicit_drive: assert property ( // RULE_24
        st_q.arb == ARB_EXPLICIT |-> !bus_driven_n && !addr_ctl_oe_n)
        else $error("explicit master not driving the bus");
endmodule

// *** hw/xba_pkg.sv ***
// Shared constants and carrier types for the external bus arbiter
package xba_pkg;

    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    localparam logic PIN_ASSERT = 1'h0;
    localparam logic PIN_NEG = 1'h1;

    // ------------------------------------------------------------
    // Transfer type codes
    // ------------------------------------------------------------
    localparam logic [1:0] XTYPE_NORMAL = 2'h0;
    localparam logic [1:0] XTYPE_DMA = 2'h1;
    localparam logic [1:0] XTYPE_EMUL = 2'h2;
    localparam logic [1:0] XTYPE_CPU_SPACE = 2'h3;

    // ------------------------------------------------------------
    // Modifier codes for normal accesses
    // ------------------------------------------------------------
    localparam logic [2:0] XMOD_PUSH = 3'h0;
    localparam logic [2:0] XMOD_USER_DATA = 3'h1;
    localparam logic [2:0] XMOD_USER_CODE = 3'h2;
    localparam logic [2:0] XMOD_RSVD_LO = 3'h3;
    localparam logic [2:0] XMOD_RSVD_HI = 3'h4;
    localparam logic [2:0] XMOD_SUPV_DATA = 3'h5;

    // ------------------------------------------------------------
    // Beat counting and synchroniser reset values
    // ------------------------------------------------------------
    localparam logic [1:0] BEAT_LAST = 2'h0;
    localparam logic [1:0] BEAT_STEP = 2'h1;
    // Order {grant_n, hard_reset_in_n, ack_n}: reset held until seen negated
    localparam logic [2:0] SYNC_RST_VAL = 3'h5;

    typedef enum logic [3:0] {
        ARB_RESET = 4'h1,
        ARB_IMPLICIT = 4'h2,
        ARB_EXPLICIT = 4'h4,
        ARB_EXTERNAL = 4'h8
    } xba_arb_e;

    // Attribute pin group: transfer-in-progress, type, modifier
    typedef struct packed {
        logic active;
        logic [1:0] xtype;
        logic [2:0] xmod;
    } xba_attr_s;

    localparam xba_attr_s ATTR_IDLE = '1;

    // Pin assignment: 1 selects the bus function, 0 the port bit
    typedef struct packed {
        logic active_bus;
        logic type_bus;
        logic mod_bus;
    } xba_pin_cfg_s;

    typedef struct packed {
        logic valid;
        logic [1:0] xtype;
        logic [2:0] xmod;
        logic [1:0] extra_beats;
    } xba_req_s;

endpackage

// *** hw/xba_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module xba_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } xba_sync_st_s;

    xba_sync_st_s st_q;
    xba_sync_st_s st_d;
    logic [W-1:0] agree_lvl;

    // ------------------------------------------------------------
    // Per-bit filter
    // ------------------------------------------------------------
    // Stage one is only read by stage two
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign agree_lvl[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i] : st_q.lvl[i];
    end

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.lvl = agree_lvl;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;

endmodule

// *** testbench/xba_far_end.sv ***
// Behavioural far side: bus arbiter grant and slave acknowledge
`timescale 1ns/10ps
module xba_far_end (
    input wire logic sys_clk,
    input wire logic three_wire,
    input wire logic grant_en,
    input wire logic slow,
    input wire logic bus_request_n,
    input wire logic xfer_start_n,
    input wire logic [1:0] beats,
    output logic bus_grant_n,
    output logic xfer_ack_n
);
    int owed = 0;

    initial begin
        bus_grant_n = 1'h1;
        xfer_ack_n = 1'h1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    always @(posedge sys_clk) begin
        #1;
        bus_grant_n = !(grant_en && (!three_wire || !bus_request_n));
    end

    // Beats owed: one per started cycle plus burst extras
    always @(posedge sys_clk) begin
        if (xfer_start_n === 1'h0) begin
            owed = owed + int'(beats) + 1;
        end
    end

    // Ack line is pulled up, so idle reads high
    always begin
        step(1);
        if (owed > 0) begin
            step(slow ? 7 : 1);
            xfer_ack_n = 1'h0;
            step(3);
            xfer_ack_n = 1'h1;
            owed = owed - 1;
            step(2);
        end
    end
endmodule

// *** testbench/tb_xba_arb.sv ***
// Self-checking bench for the bus arbiter with queued expectations
`timescale 1ns/10ps
module tb_xba_arb;
    import xba_pkg::*;
    logic sys_clk = 1'h0;
    logic nrst = 1'h0;
    logic wdog_reset = 1'h0;
    logic three_wire = 1'h0;
    logic hard_reset_in_n = 1'h0;
    logic grant_en = 1'h1;
    logic slow = 1'h0;
    xba_pin_cfg_s pin_cfg = '1;
    xba_attr_s port_dout = '0;
    xba_attr_s port_doe_n = '1;
    xba_req_s core_req = '0;
    logic bus_grant_n, xfer_ack_n, req_taken, xfer_start_n, bus_driven_n;
    logic bus_request_n, addr_ctl_oe_n, ext_master, watch_gap = 1'h0;
    xba_attr_s attr_o, attr_oe_n;
    xba_arb_e arb_state;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int gaps = 0;
    logic [31:0] rnd = 32'h45;
    logic [31:0] r;
    logic [5:0] mask;
    logic [4:0] exp_q[$];

    always #5 sys_clk = ~sys_clk;

    xba_arb dut (.sys_clk(sys_clk), .nrst(nrst), .wdog_reset(wdog_reset),
        .three_wire(three_wire), .pin_cfg(pin_cfg), .port_dout(port_dout),
        .port_doe_n(port_doe_n), .core_req(core_req), .bus_grant_n(bus_grant_n),
        .hard_reset_in_n(hard_reset_in_n), .xfer_ack_n(xfer_ack_n), .req_taken(req_taken),
        .attr_o(attr_o), .attr_oe_n(attr_oe_n), .xfer_start_n(xfer_start_n),
        .bus_driven_n(bus_driven_n), .bus_request_n(bus_request_n),
        .addr_ctl_oe_n(addr_ctl_oe_n), .ext_master(ext_master), .arb_state(arb_state));

    xba_far_end far (.sys_clk(sys_clk), .three_wire(three_wire), .grant_en(grant_en),
        .slow(slow), .bus_request_n(bus_request_n), .xfer_start_n(xfer_start_n),
        .beats(core_req.extra_beats), .bus_grant_n(bus_grant_n), .xfer_ack_n(xfer_ack_n));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] next_rnd();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    function automatic logic [2:0] exp_mod(input logic [1:0] t, input logic [2:0] m);
        if (t == XTYPE_NORMAL && (m == XMOD_RSVD_LO || m == XMOD_RSVD_HI)) return XMOD_USER_DATA;
        return m;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_state(input xba_arb_e s);
        int i;
        for (i = 0; i < 60 && arb_state !== s; i++) step(1);
        check({4'h0, arb_state}, {4'h0, s});
    endtask

    // Valid held until the taken pulse, dropped in that cycle
    task automatic req(input logic [1:0] t, input logic [2:0] m, input logic [1:0] b);
        int i;
        core_req = '{1'h1, t, m, b};
        exp_q.push_back({t, exp_mod(t, m)});
        for (i = 0; i < 300 && req_taken !== 1'h1; i++) step(1);
        check({7'h0, req_taken}, 8'h1);
        core_req.valid = 1'h0;
        step(1);
    endtask

    // Request made with no grant, then grant given
    task automatic held_req(input logic [1:0] t, input logic rq_n);
        grant_en = 1'h0;
        fork
            req(t, XMOD_USER_CODE, 2'h0);
            begin
                step(8);
                check({ext_master, bus_request_n, 6'h0}, {1'h1, rq_n, 6'h0});
                grant_en = 1'h1;
            end
        join
    endtask

    // ------------------------------------------------------------
    // Watcher: compares each started cycle against the oldest note
    // ------------------------------------------------------------
    always @(negedge sys_clk) begin
        cycles++;
        if (watch_gap && attr_o.active === 1'h1) gaps++;
        if (cycles > 20000) begin
            n_fail++;
            end_of_test();
        end else if (req_taken === 1'h1) begin
            if (exp_q.size() == 0) check(8'hff, 8'h00);
            else check({3'h0, attr_o.xtype, attr_o.xmod}, {3'h0, exp_q.pop_front()});
            check({attr_o.active, xfer_start_n, bus_driven_n, addr_ctl_oe_n, 4'h0}, 8'h0);
            check({2'h0, attr_oe_n}, 8'h0);
            if (three_wire) check({7'h0, bus_request_n}, 8'h0);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int i;
        repeat (10) @(posedge sys_clk);
        #1;
        nrst = 1'h1;
        hard_reset_in_n = 1'h1;
        wait_state(ARB_IMPLICIT);
        check({bus_driven_n, attr_o.active, attr_oe_n.active, addr_ctl_oe_n, attr_oe_n.xtype, 2'h0}, 8'hdc);
        $display("test reset exit done");
        req(XTYPE_NORMAL, XMOD_PUSH, 2'h0);
        watch_gap = 1'h1;
        for (i = 1; i < 6; i++) req(XTYPE_NORMAL, 3'(i), 2'h0);
        for (i = 0; i < 9; i++) begin
            r = next_rnd();
            slow = r[9];
            req(2'(i % 3 + 1), r[2:0], r[5:4]);
        end
        watch_gap = 1'h0;
        slow = 1'h0;
        check(8'(gaps), 8'h0);
        for (i = 0; i < 100 && attr_o.active !== 1'h1; i++) step(1);
        check({bus_driven_n, attr_o.active, attr_oe_n.active, 5'h0}, 8'h40);
        $display("test codes and back to back done");
        req(XTYPE_DMA, XMOD_USER_DATA, 2'h2);
        grant_en = 1'h0;
        for (i = 0; i < 200 && far.owed != 1; i++) step(1);
        check({ext_master, bus_driven_n, 6'h0}, 8'h0);
        wait_state(ARB_EXTERNAL);
        step(1);
        check({bus_driven_n, addr_ctl_oe_n, attr_oe_n}, 8'hff);
        check({7'h0, ext_master}, 8'h1);
        $display("test grant removal done");
        three_wire = 1'h1;
        held_req(XTYPE_CPU_SPACE, 1'h0);
        wait_state(ARB_EXTERNAL);
        check({7'h0, bus_request_n}, 8'h1);
        three_wire = 1'h0;
        held_req(XTYPE_EMUL, 1'h1);
        $display("test wire modes done");
        for (i = 0; i < 100 && attr_o.active !== 1'h1; i++) step(1);
        for (i = 0; i < 8; i++) begin
            r = next_rnd();
            pin_cfg = 3'(i);
            port_dout = r[5:0];
            port_doe_n = r[13:8];
            mask = {~pin_cfg.active_bus, {2{~pin_cfg.type_bus}}, {3{~pin_cfg.mod_bus}}};
            step(2);
            check({2'h0, attr_o & mask}, {2'h0, port_dout & mask});
            check({2'h0, attr_oe_n & mask}, {2'h0, port_doe_n & mask});
        end
        pin_cfg = '1;
        $display("test pin assignment done");
        wdog_reset = 1'h1;
        step(2);
        check({4'h0, arb_state}, {4'h0, ARB_RESET});
        wdog_reset = 1'h0;
        wait_state(ARB_IMPLICIT);
        grant_en = 1'h0;
        hard_reset_in_n = 1'h0;
        wait_state(ARB_RESET);
        check({bus_driven_n, addr_ctl_oe_n, attr_oe_n}, 8'hff);
        hard_reset_in_n = 1'h1;
        wait_state(ARB_EXTERNAL);
        check(8'(exp_q.size()), 8'h0);
        $display("test reset sources done");
        end_of_test();
    end
endmodule
